// ==== rtl/ovsc_pkg.sv ====
// shared constants and carrier types for the vbus and switch control block
package ovsc_pkg;
	localparam int OVSC_STAT_W = 8;
	localparam int OVSC_STAT_VBUS_VALID = 1;
	localparam int OVSC_STAT_SESS_VALID = 2;
	localparam int OVSC_STAT_SESS_END = 3;
	localparam logic [OVSC_STAT_W-1:0] OVSC_STAT_RST = 8'h00;
	localparam int OVSC_REG_LVL_W = 2;
	localparam logic [OVSC_REG_LVL_W-1:0] OVSC_REG_LVL_RST = 2'h0;
	localparam int OVSC_CMP_N = 3;
	localparam int OVSC_CMP_VBUS = 0;
	localparam int OVSC_CMP_SESSV = 1;
	localparam int OVSC_CMP_SESSE = 2;
	localparam logic [OVSC_CMP_N-1:0] OVSC_CMP_RST = 3'h0;
	// the external vbus indicator input is strapped high inside the device
	localparam logic OVSC_EXT_IND_LEVEL = 1'h1;
	// pin sync reset state: chip reset asserted and supply absent, switches on
	localparam logic [1:0] OVSC_PIN_RST = 2'h0;
	localparam int OVSC_PIN_RESETN = 0;
	localparam int OVSC_PIN_SUPPLY = 1;

	typedef struct packed {
		logic sessionEndCmp;
		logic sessionValidCmp;
		logic vbusValidCmp;
	} ovsc_cmp_t;

	typedef struct packed {
		logic vbusValidRiseEn;
		logic vbusValidFallEn;
		logic sessValidRiseEn;
		logic sessValidFallEn;
		logic sessEndRiseEn;
		logic sessEndFallEn;
		logic useExtVbusInd;
		logic indPassThru;
		logic indComplement;
		logic vbusDischargeCtl;
		logic vbusChargeCtl;
		logic uartMode;
		logic [OVSC_REG_LVL_W-1:0] uartRegulatorLevel;
		logic dpWeakPullupEn;
		logic dmWeakPullupEn;
		logic leftSpeakerSwitchEn;
		logic rightSpeakerSwitchEn;
		logic microphoneSwitchEn;
	} ovsc_cfg_t;

	localparam ovsc_cfg_t OVSC_CFG_RST = '0;

	typedef struct packed {
		logic dpAudioSwitchOn;
		logic dmAudioSwitchOn;
		logic seRxEnable;
		logic dpWeakPullupOn;
		logic dmWeakPullupOn;
		logic vbusDischargeOn;
		logic vbusChargeOn;
		logic lineStateOutEn;
	} ovsc_drv_t;

	localparam ovsc_drv_t OVSC_DRV_RST = 8'hc0;
endpackage : ovsc_pkg

// ==== rtl/ovsc_sync.sv ====
// two flip-flop synchroniser for asynchronous level inputs
module ovsc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// the first stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= asyncIn;
			sync_ff <= meta_ff;
		end
	end

	assign syncOut = sync_ff;
endmodule : ovsc_sync

// ==== rtl/ovsc_vbus_switch_ctl.sv ====
// vbus comparator decode, vbus pulsing, uart regulator, pull-ups and audio switches
// Overview of operation
// - vbus-valid forced off when both enables clear
// - external indicator off selects internal comparator
// - indicator decode: pass gives 1, complement 0
// - indicator selection logic disabled after reset
// - discharge bit drives vbus pull-down
// - charge bit drives vbus pull-up
// - uart entry loads uart regulator level
// - no line state on data 0,1 in uart
// - chip reset forces weak pull-ups off
// - audio switches off normally, enables reset cleared
// - no supply or chip reset forces switches on
// - dp follows left, dm right or mic
// - audio switch on disables single-ended receivers
// - session-end off when both enables clear
module ovsc_vbus_switch_ctl
	import ovsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire ovsc_cmp_t cmpRaw,
	input wire logic chipResetN,
	input wire logic coreSupply1v8,
	input wire ovsc_cfg_t cfgIn,
	input wire logic [OVSC_REG_LVL_W-1:0] normalRegulatorLevel,
	output logic [OVSC_STAT_W-1:0] intStatus,
	output logic [OVSC_CMP_N-1:0] cmpRiseEvt,
	output logic [OVSC_CMP_N-1:0] cmpFallEvt,
	output logic rxcmdVbusValid,
	output logic [OVSC_REG_LVL_W-1:0] regulatorLevel,
	output ovsc_drv_t drive
);
	ovsc_cmp_t cmpSync;
	logic [1:0] pinSync;
	ovsc_cfg_t cfg_ff;
	ovsc_cfg_t nxt_cfg;
	logic [OVSC_STAT_W-1:0] status_ff;
	logic [OVSC_STAT_W-1:0] nxt_status;
	logic [OVSC_CMP_N-1:0] seen_ff;
	logic [OVSC_CMP_N-1:0] nxt_seen;
	logic [OVSC_CMP_N-1:0] rise_ff;
	logic [OVSC_CMP_N-1:0] nxt_rise;
	logic [OVSC_CMP_N-1:0] fall_ff;
	logic [OVSC_CMP_N-1:0] nxt_fall;
	logic [OVSC_CMP_N-1:0] riseEn;
	logic [OVSC_CMP_N-1:0] fallEn;
	logic rxVbus_ff;
	logic nxt_rxVbus;
	logic uartPrev_ff;
	logic uartEntry;
	logic [OVSC_REG_LVL_W-1:0] regLvl_ff;
	logic [OVSC_REG_LVL_W-1:0] nxt_regLvl;
	ovsc_drv_t drv_ff;
	ovsc_drv_t nxt_drv;
	logic chipResetNSync;
	logic supplySync;
	logic vbusCmpOn;
	logic sessEndCmpOn;
	logic vbusSeen;
	logic sessEndSeen;
	logic extIndValue;
	logic forceSwitchOn;
	logic dpSwitch;
	logic dmSwitch;

	ovsc_sync #(
		.WIDTH(OVSC_CMP_N),
		.RST_VAL(OVSC_CMP_RST)
	) u_cmpSync (
		.clk(clk),
		.rst(rst),
		.asyncIn(cmpRaw),
		.syncOut(cmpSync)
	);

	// reset state assumes the worst case: chip in reset, no supply
	ovsc_sync #(
		.WIDTH(2),
		.RST_VAL(OVSC_PIN_RST)
	) u_pinSync (
		.clk(clk),
		.rst(rst),
		.asyncIn({coreSupply1v8, chipResetN}),
		.syncOut(pinSync)
	);

	assign chipResetNSync = pinSync[OVSC_PIN_RESETN];
	assign supplySync = pinSync[OVSC_PIN_SUPPLY];

	// configuration follows the register array, cleared while the chip reset pin is low
	assign nxt_cfg = chipResetNSync ? cfgIn : OVSC_CFG_RST;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_ff <= OVSC_CFG_RST;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	// comparator enable decode
	assign vbusCmpOn = cfg_ff.vbusValidRiseEn | cfg_ff.vbusValidFallEn;
	assign sessEndCmpOn = cfg_ff.sessEndRiseEn | cfg_ff.sessEndFallEn;
	assign vbusSeen = cmpSync.vbusValidCmp & vbusCmpOn;
	assign sessEndSeen = cmpSync.sessionEndCmp & sessEndCmpOn;

	// session valid is never disabled, only its events are
	assign nxt_seen = {sessEndSeen, cmpSync.sessionValidCmp, vbusSeen};
	assign riseEn = {cfg_ff.sessEndRiseEn, cfg_ff.sessValidRiseEn, cfg_ff.vbusValidRiseEn};
	assign fallEn = {cfg_ff.sessEndFallEn, cfg_ff.sessValidFallEn, cfg_ff.vbusValidFallEn};
	assign nxt_rise = nxt_seen & ~seen_ff & riseEn;
	assign nxt_fall = ~nxt_seen & seen_ff & fallEn;

	assign nxt_status = OVSC_STAT_RST
		| (OVSC_STAT_W'(vbusSeen) << OVSC_STAT_VBUS_VALID)
		| (OVSC_STAT_W'(cmpSync.sessionValidCmp) << OVSC_STAT_SESS_VALID)
		| (OVSC_STAT_W'(sessEndSeen) << OVSC_STAT_SESS_END);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_ff <= OVSC_STAT_RST;
			seen_ff <= OVSC_CMP_RST;
			rise_ff <= OVSC_CMP_RST;
			fall_ff <= OVSC_CMP_RST;
		end else begin
			status_ff <= nxt_status;
			seen_ff <= nxt_seen;
			rise_ff <= nxt_rise;
			fall_ff <= nxt_fall;
		end
	end

	// external indicator decode; complement wins over pass-through
	assign extIndValue = cfg_ff.indComplement ? 1'h0 :
		(cfg_ff.indPassThru ? OVSC_EXT_IND_LEVEL : vbusSeen);
	assign nxt_rxVbus = cfg_ff.useExtVbusInd ? extIndValue : vbusSeen;

	// uart regulator level is captured on entry and held until uart mode ends
	assign uartEntry = cfg_ff.uartMode & ~uartPrev_ff;
	assign nxt_regLvl = uartEntry ? cfg_ff.uartRegulatorLevel :
		(cfg_ff.uartMode ? regLvl_ff : normalRegulatorLevel);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxVbus_ff <= 1'h0;
			uartPrev_ff <= 1'h0;
			regLvl_ff <= OVSC_REG_LVL_RST;
		end else begin
			rxVbus_ff <= nxt_rxVbus;
			uartPrev_ff <= cfg_ff.uartMode;
			regLvl_ff <= nxt_regLvl;
		end
	end

	// pin-level forcing bypasses cfg_ff so the switches close three cycles after the pin
	assign forceSwitchOn = ~supplySync | ~chipResetNSync;
	assign dpSwitch = forceSwitchOn | cfg_ff.leftSpeakerSwitchEn;
	assign dmSwitch = forceSwitchOn | cfg_ff.rightSpeakerSwitchEn
		| cfg_ff.microphoneSwitchEn;

	assign nxt_drv.dpAudioSwitchOn = dpSwitch;
	assign nxt_drv.dmAudioSwitchOn = dmSwitch;
	assign nxt_drv.seRxEnable = ~(dpSwitch | dmSwitch);
	assign nxt_drv.dpWeakPullupOn = chipResetNSync & cfg_ff.dpWeakPullupEn;
	assign nxt_drv.dmWeakPullupOn = chipResetNSync & cfg_ff.dmWeakPullupEn;
	assign nxt_drv.vbusDischargeOn = cfg_ff.vbusDischargeCtl;
	assign nxt_drv.vbusChargeOn = cfg_ff.vbusChargeCtl;
	assign nxt_drv.lineStateOutEn = ~cfg_ff.uartMode;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drv_ff <= OVSC_DRV_RST;
		end else begin
			drv_ff <= nxt_drv;
		end
	end

	assign intStatus = status_ff;
	assign cmpRiseEvt = rise_ff;
	assign cmpFallEvt = fall_ff;
	assign rxcmdVbusValid = rxVbus_ff;
	assign regulatorLevel = regLvl_ff;
	assign drive = drv_ff;
endmodule : ovsc_vbus_switch_ctl

// ==== testbench/ovsc_link_model.sv ====
// link side model: register array whose levels feed the block's configuration
module ovsc_link_model
	import ovsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic wrEn,
	input wire ovsc_cfg_t wrData,
	output ovsc_cfg_t cfgOut
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cfgOut <= OVSC_CFG_RST;
		else if (wrEn)
			cfgOut <= wrData;
	end
endmodule : ovsc_link_model

// ==== testbench/ovsc_vbus_switch_ctl_props.sv ====
// port assertions for the vbus and switch control block
module ovsc_props
	import ovsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic chipResetN,
	input wire logic coreSupply1v8,
	input wire ovsc_cfg_t cfgIn,
	input wire logic [OVSC_STAT_W-1:0] intStatus,
	input wire logic rxcmdVbusValid,
	input wire logic [OVSC_REG_LVL_W-1:0] regulatorLevel,
	input wire ovsc_drv_t drive
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// five high samples cover two sync stages, the config flop and the output flop
	AST_DISCHARGE: assert property (chipResetN[*5] |->
		drive.vbusDischargeOn == $past(cfgIn.vbusDischargeCtl, 2)) else $error("discharge wrong");
	AST_CHARGE: assert property (chipResetN[*5] |->
		drive.vbusChargeOn == $past(cfgIn.vbusChargeCtl, 2)) else $error("charge wrong");
	AST_PULLUP_OFF: assert property ((!chipResetN)[*4] |->
		!drive.dpWeakPullupOn && !drive.dmWeakPullupOn) else $error("pull-up on in reset");
	AST_SWITCH_ON: assert property ((!chipResetN || !coreSupply1v8)[*4] |->
		drive.dpAudioSwitchOn && drive.dmAudioSwitchOn) else $error("switch not forced");
	AST_SE_RX: assert property (
		drive.seRxEnable != (drive.dpAudioSwitchOn || drive.dmAudioSwitchOn)) else $error("se rx");
	AST_VBUS_OFF: assert property (
		(chipResetN && !cfgIn.vbusValidRiseEn && !cfgIn.vbusValidFallEn)[*5] |->
		!intStatus[OVSC_STAT_VBUS_VALID]) else $error("vbus status not gated");
	AST_COMPL: assert property (
		(chipResetN && cfgIn.useExtVbusInd && cfgIn.indComplement)[*5] |->
		!rxcmdVbusValid) else $error("complement not zero");
	AST_UART: assert property (chipResetN[*4] ##1 (chipResetN && $rose(cfgIn.uartMode)) |->
		##2 regulatorLevel == $past(cfgIn.uartRegulatorLevel, 2)) else $error("uart level");
	cover property (drive.vbusChargeOn);
	cover property ($rose(drive.dpAudioSwitchOn));
	cover property (!drive.lineStateOutEn);
endmodule : ovsc_props

bind ovsc_vbus_switch_ctl ovsc_props i_props (.clk, .rst, .chipResetN, .coreSupply1v8, .cfgIn,
	.intStatus, .rxcmdVbusValid, .regulatorLevel, .drive);

// ==== testbench/tb_top.sv ====
// self-checking bench for the vbus and switch control block
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("Error at %0t: mismatch", $time); end end
module tb_top
	import ovsc_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, wrEn, chipResetN, coreSupply1v8, rxcmdVbusValid;
	ovsc_cmp_t cmpRaw;
	ovsc_cfg_t wrData, cfgIn;
	logic [1:0] normalRegulatorLevel, regulatorLevel;
	logic [7:0] intStatus;
	logic [2:0] rise;
	logic [2:0] fall;
	ovsc_drv_t drive;
	int fails, cmp_count, cycles;
	ovsc_link_model i_link (.clk, .rst, .wrEn, .wrData, .cfgOut(cfgIn));
	ovsc_vbus_switch_ctl i_dut (.clk, .rst, .cmpRaw, .chipResetN, .coreSupply1v8, .cfgIn,
		.normalRegulatorLevel, .intStatus, .cmpRiseEvt(rise), .cmpFallEvt(fall), .rxcmdVbusValid,
		.regulatorLevel, .drive);
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	// one register write by the link, then wait until the levels reach the pins
	task automatic wr(ovsc_cfg_t c);
		@(posedge clk);
		wrData <= c;
		wrEn <= 1'h1;
		@(posedge clk);
		wrEn <= 1'h0;
		step(4);
	endtask : wr
	task automatic pins(logic rn, logic sup);
		@(posedge clk);
		chipResetN <= rn;
		coreSupply1v8 <= sup;
		step(5);
	endtask : pins
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// the whole sequence needs under 1200 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		ovsc_cfg_t c;
		{rst, wrEn, chipResetN, coreSupply1v8} = 4'hb;
		wrData = OVSC_CFG_RST;
		cmpRaw = OVSC_CMP_RST;
		normalRegulatorLevel = 2'h2;
		repeat (10) @(posedge clk);
		`CHK(drive, OVSC_DRV_RST)
		rst <= 1'h0;
		step(5);
		`CHK(drive, 8'h21)
		c = OVSC_CFG_RST;
		c.vbusValidRiseEn = 1'h1;
		wr(c);
		@(posedge clk);
		cmpRaw <= 3'h1;
		step(3);
		`CHK(rise, 3'h1)
		`CHK(rxcmdVbusValid, 1'h1)
		step(1);
		`CHK(rise, 3'h0)
		for (int i = 0; i < 16; i++) begin
			{c.indComplement, c.indPassThru, c.useExtVbusInd} = i[2:0];
			@(posedge clk);
			cmpRaw <= {2'h0, i[3]};
			wr(c);
			`CHK(rxcmdVbusValid, !i[0] ? i[3] : i[2] ? 1'h0 : i[1] ? 1'h1 : i[3])
		end
		@(posedge clk);
		cmpRaw <= 3'h7;
		wr(OVSC_CFG_RST);
		`CHK(intStatus, 8'h04)
		c = OVSC_CFG_RST;
		{c.vbusValidFallEn, c.sessEndRiseEn} = 2'h3;
		wr(c);
		`CHK(intStatus, 8'h0e)
		// vbus drops with only its fall event enabled: one pulse after the two sync stages
		@(posedge clk);
		cmpRaw <= 3'h6;
		step(3);
		`CHK(fall, 3'h1)
		step(1);
		`CHK(fall, 3'h0)
		$display("comparator test done");
		for (int i = 0; i < 128; i++) begin
			c = OVSC_CFG_RST;
			{c.vbusDischargeCtl, c.vbusChargeCtl, c.dpWeakPullupEn, c.dmWeakPullupEn,
				c.leftSpeakerSwitchEn, c.rightSpeakerSwitchEn, c.microphoneSwitchEn} = i[6:0];
			wr(c);
			`CHK(drive[7:1], {i[2], i[1] | i[0], !(|i[2:0]), i[4:3], i[6:5]})
		end
		c = OVSC_CFG_RST;
		{c.dpWeakPullupEn, c.dmWeakPullupEn} = 2'h3;
		wr(c);
		pins(1'h0, 1'h1);
		`CHK(drive[7:3], 5'h18)
		pins(1'h1, 1'h0);
		`CHK(drive[7:3], 5'h1b)
		pins(1'h1, 1'h1);
		`CHK(drive[7:3], 5'h07)
		$display("drive test done");
		c = OVSC_CFG_RST;
		c.uartRegulatorLevel = 2'h1;
		wr(c);
		c.uartMode = 1'h1;
		wr(c);
		`CHK({regulatorLevel, drive.lineStateOutEn}, 3'h2)
		c.uartMode = 1'h0;
		wr(c);
		`CHK({regulatorLevel, drive.lineStateOutEn}, 3'h5)
		$display("uart test done");
		final_report();
	end
endmodule : tb_top
